// ### bench/host_side_model.sv
/*
 * Host-side model: sends glyph RAM host requests one at a time.
 * Assumes the lookup block samples its host strobes on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module host_side_model
	import glyph_lookup_pkg::*;
(
	// Clock and format
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_glyph_fmt,
	// Host strobes
	output logic                         o_addr_load,
	output logic      [GLYPH_ADDR_W-1:0] o_addr,
	output logic                         o_wr,
	output logic      [GLYPH_DATA_W-1:0] o_wdata,
	output logic                         o_rd,
	output logic                         o_entry_incr
);
	logic [GLYPH_ADDR_W-1:0] ctr;

	initial begin
		{o_addr_load, o_wr, o_rd, o_entry_incr} = 4'h1;
		o_addr = 6'h00;
		o_wdata = 8'h00;
		ctr = 6'h00;
	end

	// Held over one rising edge, then released with inverted bus values
	task automatic put(input host_op_t op, input logic [5:0] a, input logic [7:0] d,
			input bit raw);
		@(negedge i_ref_clk);
		o_addr_load = (op == HOST_LOAD);
		o_wr = (op == HOST_WRITE);
		o_rd = (op == HOST_READ);
		o_addr = a;
		o_wdata = (!raw && op == HOST_WRITE && i_glyph_fmt == FMT_5X8 && ctr[2:0] == 3'h7)
			? {d[7:5], 5'h00} : d;
		if (op == HOST_LOAD) begin
			ctr = a;
		end else if (op != HOST_IDLE) begin
			ctr = o_entry_incr ? ctr + 6'h01 : ctr - 6'h01;
		end
		@(negedge i_ref_clk);
		{o_addr_load, o_wr, o_rd} = 3'h0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask

	task automatic set_dir(input logic up);
		@(negedge i_ref_clk);
		o_entry_incr = up;
	endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
/*
 * Self-checking bench for the user glyph RAM lookup.
 * Assumes the host model drives the host port and the bench drives the scan port.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import glyph_lookup_pkg::*;
	logic       ref_clk, reset, glyph_fmt, scan_req, load, wr, rd, incr;
	logic       rvalid, svalid, sfixed;
	logic [5:0] haddr, ctr;
	logic [7:0] wdata, rdata, scode;
	logic [3:0] srow;
	logic [4:0] cursor, dots;
	logic [7:0] shadow [64];
	int         err_total, n_compared;

	user_glyph_ram_lookup u_user_glyph_ram_lookup (.i_ref_clk(ref_clk), .i_reset(reset),
		.i_glyph_fmt(glyph_fmt), .i_host_addr_load(load), .i_host_addr(haddr),
		.i_host_wr(wr), .i_host_wdata(wdata), .i_host_rd(rd), .i_entry_incr(incr),
		.o_host_rdata(rdata), .o_host_rdata_valid(rvalid), .o_address_counter(ctr),
		.i_scan_req(scan_req), .i_scan_code(scode), .i_scan_row(srow),
		.i_cursor_dots(cursor), .o_scan_valid(svalid), .o_scan_fixed(sfixed),
		.o_scan_dots(dots));
	host_side_model u_host_side_model (.i_ref_clk(ref_clk), .i_glyph_fmt(glyph_fmt),
		.o_addr_load(load), .o_addr(haddr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
		.o_entry_incr(incr));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic scan(input logic [7:0] c, input logic [3:0] r, input logic [4:0] cur,
			input logic [4:0] e, input logic fx);
		@(negedge ref_clk);
		{scan_req, scode, srow, cursor} = {1'b1, c, r, cur};
		@(negedge ref_clk);
		{scan_req, scode, cursor} = {1'b0, ~c, ~cur};
		chk("scan valid", 8'h01, {7'h00, svalid});
		chk("scan fixed", {7'h00, fx}, {7'h00, sfixed});
		chk("scan dots", {3'h0, e}, {3'h0, dots});
	endtask

	task automatic t_host();
		logic [7:0] d;
		u_host_side_model.set_dir(1'b1);
		u_host_side_model.put(HOST_LOAD, 6'h08, 8'h00, 1'b0);
		for (int r = 0; r < 8; r++) begin
			d = (r == 7) ? 8'he0 : 8'he0 | (8'h11 + 8'(r));
			u_host_side_model.put(HOST_WRITE, 6'h00, d, 1'b0);
			shadow[8 + r] = d;
			chk("counter up", 8'(9 + r), {2'h0, ctr});
		end
		u_host_side_model.set_dir(1'b0);
		u_host_side_model.put(HOST_LOAD, 6'h0f, 8'h00, 1'b0);
		for (int r = 7; r >= 0; r--) begin
			u_host_side_model.put(HOST_READ, 6'h00, 8'h00, 1'b0);
			chk("read valid", 8'h01, {7'h00, rvalid});
			chk("read data", shadow[8 + r], rdata);
			chk("counter down", 8'(7 + r), {2'h0, ctr});
		end
		u_host_side_model.put(HOST_LOAD, 6'h00, 8'h00, 1'b0);
		u_host_side_model.put(HOST_READ, 6'h00, 8'h00, 1'b0);
		chk("counter wrap", 8'h3f, {2'h0, ctr});
		$display("test host access done");
	endtask

	task automatic t_narrow();
		logic [4:0] e;
		glyph_fmt = FMT_5X8;
		foreach (shadow[i]) begin
			if (i >= 8 && i < 16) begin
				e = shadow[i][4:0] | ((i % 8 == 7) ? 5'h0a : 5'h00);
				scan(8'h01, 4'(i % 8), 5'h0a, e, 1'b0);
				scan(8'h09, 4'(i % 8), 5'h0a, e, 1'b0);
			end
		end
		scan(8'h10, 4'h0, 5'h00, 5'h00, 1'b1);
		scan(8'h20, 4'h1, 5'h00, 5'h00, 1'b1);
		scan(8'h41, 4'h2, 5'h00, 5'h00, 1'b1);
		scan(8'h81, 4'h3, 5'h00, 5'h00, 1'b1);
		$display("test narrow lookup done");
	endtask

	task automatic t_tall();
		glyph_fmt = FMT_5X10;
		u_host_side_model.set_dir(1'b1);
		u_host_side_model.put(HOST_LOAD, 6'h10, 8'h00, 1'b0);
		for (int r = 0; r < 12; r++) begin
			u_host_side_model.put(HOST_WRITE, 6'h00, (r == 10) ? 8'h00 : 8'h05 + 8'(r), 1'b0);
		end
		for (int r = 0; r < 11; r++) begin
			scan(8'h03, 4'(r), 5'h11, (r == 10) ? 5'h11 : 5'(5 + r), 1'b0);
		end
		scan(8'h03, 4'hb, 5'h11, 5'h00, 1'b0);
		scan(8'h02, 4'h0, 5'h00, 5'h05, 1'b0);
		$display("test tall lookup done");
	endtask

	task automatic t_cursor_row();
		glyph_fmt = FMT_5X8;
		u_host_side_model.put(HOST_LOAD, 6'h07, 8'h00, 1'b0);
		u_host_side_model.put(HOST_WRITE, 6'h00, 8'h04, 1'b1);
		scan(8'h00, 4'h7, 5'h00, 5'h04, 1'b0);
		scan(8'h08, 4'h7, 5'h10, 5'h14, 1'b0);
		u_host_side_model.put(HOST_LOAD, 6'h07, 8'h00, 1'b0);
		fork
			u_host_side_model.put(HOST_WRITE, 6'h00, 8'h00, 1'b1);
			begin
				@(negedge ref_clk);
				scan(8'h00, 4'h7, 5'h00, 5'h00, 1'b0);
			end
		join
		$display("test cursor row done");
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		complete_run();
	end

	initial begin
		{reset, glyph_fmt, scan_req, scode, srow, cursor} = {1'b1, 1'b0, 1'b0, 8'h00, 4'h0, 5'h00};
		err_total = 0;
		n_compared = 0;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		chk("counter reset", 8'h00, {2'h0, ctr});
		chk("dots reset", 8'h00, {3'h0, dots});
		t_host();
		t_narrow();
		t_tall();
		t_cursor_row();
		complete_run();
	end
endmodule

`default_nettype wire

// ### hdl/glyph_lookup_pkg.sv
/*
 * Shared constants and types for the user glyph RAM lookup block.
 * Assumes a single 100 MHz system clock and an asynchronous active-high reset.
 */
package glyph_lookup_pkg;

	// Storage geometry
	localparam int GLYPH_ADDR_W = 6;
	localparam int GLYPH_DATA_W = 8;
	localparam int GLYPH_DEPTH  = 64;
	localparam int DOT_W        = 5;
	localparam int CODE_W       = 8;
	localparam int ROW_W        = 4;

	// Field positions
	localparam int CODE_FONT_LSB    = 4;
	localparam int CODE_IGNORED_BIT = 3;
	localparam int NARROW_ROW_W     = 3;

	// Last row of each cell, which is also the cursor row
	localparam logic [ROW_W-1:0] NARROW_LAST_ROW = 4'h7;
	localparam logic [ROW_W-1:0] TALL_LAST_ROW   = 4'ha;

	// Values after reset, and the counter step
	localparam logic [GLYPH_ADDR_W-1:0] ADDR_RESET = 6'h00;
	localparam logic [GLYPH_DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [DOT_W-1:0]        DOTS_RESET = 5'h00;
	localparam logic [GLYPH_ADDR_W-1:0] ADDR_STEP  = 6'h01;

	// Cycles from an accepted request to its answer
	localparam int ANSWER_CYCLES = 1;

	typedef enum logic {
		FMT_5X8  = 1'b0,
		FMT_5X10 = 1'b1
	} glyph_fmt_t;

	typedef enum logic [1:0] {
		HOST_IDLE  = 2'b00,
		HOST_WRITE = 2'b01,
		HOST_READ  = 2'b10,
		HOST_LOAD  = 2'b11
	} host_op_t;

endpackage

// ### hdl/glyph_ram_store.sv
/*
 * Flip-flop glyph storage with one write port and two independent read ports.
 * Assumes write strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module glyph_ram_store
	import glyph_lookup_pkg::*;
#(
	parameter int ADDR_W = GLYPH_ADDR_W,
	parameter int DATA_W = GLYPH_DATA_W
) (
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	// Write port
	input  wire logic              i_wr_en,
	input  wire logic [ADDR_W-1:0] i_wr_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	// Host read port
	input  wire logic [ADDR_W-1:0] i_host_addr,
	output logic      [DATA_W-1:0] o_host_data,
	// Scan read port
	input  wire logic [ADDR_W-1:0] i_scan_addr,
	output logic      [DATA_W-1:0] o_scan_data
);

	localparam int DEPTH = 1 << ADDR_W;

	logic [DATA_W-1:0] mem_ff [DEPTH];

	// Separate read ports keep host traffic off the scan path
	assign o_host_data = mem_ff[i_host_addr];
	assign o_scan_data = mem_ff[i_scan_addr];

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (i_wr_en) begin
			mem_ff[i_wr_addr] <= i_wr_data;
		end
	end

endmodule

`default_nettype wire

// ### hdl/user_glyph_ram_lookup.sv
/*
 * User glyph RAM lookup: host access with auto-stepping address counter,
 * and scan lookup returning one dot row per character code and line.
 * Assumes host strobes and scan requests come from logic on i_ref_clk.
 */
// Summary of operation
// RULE_01: Store eight 5x8 glyphs or four 5x10 glyphs in 64 bytes.
// RULE_02: Host may rewrite any glyph byte at any time.
// RULE_03: Byte bits 0 to 4 form a dot row, bit 4 leftmost.
// RULE_04: 5x8: code bits 0 to 2 become glyph address bits 3 to 5.
// RULE_05: A one bit lights its dot, a zero bit leaves it dark.
// RULE_06: 5x8: glyph address bits 0 to 2 select the row.
// RULE_07: 5x8: eighth row is cursor row, cursor ORed with stored data.
// RULE_08: Host writes zeros into the cursor row of each glyph; the host model clears the dot bits there in 5x8 only.
// RULE_09: Stored ones in the cursor row light regardless of cursor.
// RULE_10: Codes with bits 4 to 7 zero use RAM, others fixed font.
// RULE_11: Code bit 3 is ignored; 00H and 08H show the same glyph.
// RULE_12: 5x10: code bits 1 and 2 become glyph address bits 4, 5.
// RULE_13: 5x10: address bits 0 to 3 select row; eleventh is cursor row.
// RULE_14: Each host read or write steps the counter by one.
// RULE_15: Byte bits 5 to 7 never affect displayed dots.
// RULE_16: Host port and scan port are separate read paths.
`timescale 1ns/1ps
`default_nettype none

module user_glyph_ram_lookup
	import glyph_lookup_pkg::*;
(
	// Clock and reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset,
	// Format select
	input  wire logic                    i_glyph_fmt,
	// Host access
	input  wire logic                    i_host_addr_load,
	input  wire logic [GLYPH_ADDR_W-1:0] i_host_addr,
	input  wire logic                    i_host_wr,
	input  wire logic [GLYPH_DATA_W-1:0] i_host_wdata,
	input  wire logic                    i_host_rd,
	input  wire logic                    i_entry_incr,
	output logic      [GLYPH_DATA_W-1:0] o_host_rdata,
	output logic                         o_host_rdata_valid,
	output logic      [GLYPH_ADDR_W-1:0] o_address_counter,
	// Display scan
	input  wire logic                    i_scan_req,
	input  wire logic [CODE_W-1:0]       i_scan_code,
	input  wire logic [ROW_W-1:0]        i_scan_row,
	input  wire logic [DOT_W-1:0]        i_cursor_dots,
	output logic                         o_scan_valid,
	output logic                         o_scan_fixed,
	output logic      [DOT_W-1:0]        o_scan_dots
);

	// Host side state
	logic [GLYPH_ADDR_W-1:0] address_counter_ff;
	logic [GLYPH_ADDR_W-1:0] nxt_address_counter;
	logic [GLYPH_DATA_W-1:0] host_rdata_ff;
	logic                    host_rdata_valid_ff;
	// Scan side state
	logic                    scan_valid_ff;
	logic                    scan_fixed_ff;
	logic [DOT_W-1:0]        scan_dots_ff;
	logic [DOT_W-1:0]        nxt_scan_dots;

	// Decode
	glyph_fmt_t              glyph_fmt;
	host_op_t                host_op;
	logic [GLYPH_ADDR_W-1:0] counter_stepped;
	logic [GLYPH_ADDR_W-1:0] scan_addr;
	logic [GLYPH_DATA_W-1:0] ram_host_data;
	logic [GLYPH_DATA_W-1:0] ram_scan_data;
	logic [ROW_W-1:0]        last_row;
	logic                    code_is_user;
	logic                    row_in_cell;
	logic                    row_is_cursor;
	logic [DOT_W-1:0]        stored_dots;

	function automatic logic [GLYPH_ADDR_W-1:0] glyph_addr(
		input logic [CODE_W-1:0] code,
		input logic [ROW_W-1:0]  row,
		input glyph_fmt_t        fmt
	);
		if (fmt == FMT_5X10) begin
			glyph_addr = {code[2:1], row}; // see RULE_12 see RULE_13
		end else begin
			glyph_addr = {code[2:0], row[NARROW_ROW_W-1:0]}; // see RULE_04 see RULE_06
		end
	endfunction

	assign glyph_fmt = glyph_fmt_t'(i_glyph_fmt);

	// Host operation priority: address load, then write, then read
	assign host_op = i_host_addr_load ? HOST_LOAD  :
	                 i_host_wr        ? HOST_WRITE :
	                 i_host_rd        ? HOST_READ  : HOST_IDLE;

	// Counter wraps within the 64-byte glyph space
	assign counter_stepped = i_entry_incr ? address_counter_ff + ADDR_STEP
	                                      : address_counter_ff - ADDR_STEP; // see RULE_14

	always_comb begin
		nxt_address_counter = address_counter_ff;
		case (host_op)
			HOST_LOAD:  nxt_address_counter = i_host_addr;
			HOST_WRITE: nxt_address_counter = counter_stepped; // see RULE_14
			HOST_READ:  nxt_address_counter = counter_stepped; // see RULE_14
			default:    nxt_address_counter = address_counter_ff;
		endcase
	end

	// Scan decode; code bit 3 is simply never looked at
	assign scan_addr     = glyph_addr(i_scan_code, i_scan_row, glyph_fmt); // see RULE_11
	assign code_is_user  = (i_scan_code[CODE_W-1:CODE_FONT_LSB] == '0); // see RULE_10
	assign last_row      = (glyph_fmt == FMT_5X10) ? TALL_LAST_ROW : NARROW_LAST_ROW; // see RULE_01
	assign row_in_cell   = (i_scan_row <= last_row);
	assign row_is_cursor = (i_scan_row == last_row); // see RULE_07 see RULE_13
	assign stored_dots   = ram_scan_data[DOT_W-1:0]; // see RULE_03 see RULE_15

	// Stored ones stay lit on the cursor row whether or not the cursor is here
	assign nxt_scan_dots = !code_is_user || !row_in_cell ? DOTS_RESET :
	                       row_is_cursor ? (stored_dots | i_cursor_dots) : // see RULE_07 see RULE_09
	                       stored_dots; // see RULE_05

	glyph_ram_store #(
		.ADDR_W (GLYPH_ADDR_W),
		.DATA_W (GLYPH_DATA_W)
	) u_store (
		.i_ref_clk   (i_ref_clk),
		.i_reset     (i_reset),
		.i_wr_en     (host_op == HOST_WRITE), // see RULE_02
		.i_wr_addr   (address_counter_ff),
		.i_wr_data   (i_host_wdata),
		.i_host_addr (address_counter_ff),
		.o_host_data (ram_host_data),
		.i_scan_addr (scan_addr), // see RULE_16
		.o_scan_data (ram_scan_data)
	);

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			address_counter_ff <= ADDR_RESET;
		end else begin
			address_counter_ff <= nxt_address_counter;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			host_rdata_ff       <= DATA_RESET;
			host_rdata_valid_ff <= 1'b0;
		end else begin
			host_rdata_valid_ff <= (host_op == HOST_READ);
			if (host_op == HOST_READ) begin
				host_rdata_ff <= ram_host_data;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			scan_valid_ff <= 1'b0;
			scan_fixed_ff <= 1'b0;
			scan_dots_ff  <= DOTS_RESET;
		end else begin
			scan_valid_ff <= i_scan_req;
			if (i_scan_req) begin
				scan_fixed_ff <= !code_is_user; // see RULE_10
				scan_dots_ff  <= nxt_scan_dots;
			end
		end
	end

	assign o_address_counter  = address_counter_ff;
	assign o_host_rdata       = host_rdata_ff;
	assign o_host_rdata_valid = host_rdata_valid_ff;
	assign o_scan_valid       = scan_valid_ff;
	assign o_scan_fixed       = scan_fixed_ff;
	assign o_scan_dots        = scan_dots_ff;

	// Checks
	sequence s_user_scan;
		i_scan_req && code_is_user && row_in_cell;
	endsequence

	sequence s_write_then_scan;
		(host_op == HOST_WRITE) ##1
		(i_scan_req && scan_addr == $past(address_counter_ff));
	endsequence

	property p_user_dots;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_user_scan and !row_is_cursor |=>
			o_scan_valid && !o_scan_fixed && o_scan_dots == $past(ram_scan_data[DOT_W-1:0]);
	endproperty
	a_user_dots: assert property (p_user_dots) else $error("stored row not shown"); // see RULE_05

	property p_cursor_or;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_user_scan and row_is_cursor |=>
			o_scan_dots == ($past(ram_scan_data[DOT_W-1:0]) | $past(i_cursor_dots));
	endproperty
	a_cursor_or: assert property (p_cursor_or) else $error("cursor row not ORed"); // see RULE_07

	property p_fixed_font;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req && i_scan_code[CODE_W-1:CODE_FONT_LSB] != '0 |=>
			o_scan_valid && o_scan_fixed && o_scan_dots == DOTS_RESET;
	endproperty
	a_fixed_font: assert property (p_fixed_font) else $error("fixed font code took RAM"); // see RULE_10

	property p_bit3_ignored;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req |-> scan_addr ==
			glyph_addr(i_scan_code ^ (8'h01 << CODE_IGNORED_BIT), i_scan_row, glyph_fmt);
	endproperty
	a_bit3_ignored: assert property (p_bit3_ignored) else $error("code bit 3 matters"); // see RULE_11

	property p_narrow_addr;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req && glyph_fmt == FMT_5X8 |->
			scan_addr[5:3] == i_scan_code[2:0] && scan_addr[2:0] == i_scan_row[2:0];
	endproperty
	a_narrow_addr: assert property (p_narrow_addr) else $error("5x8 address wrong"); // see RULE_04

	property p_tall_addr;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req && glyph_fmt == FMT_5X10 |->
			scan_addr[5:4] == i_scan_code[2:1] && scan_addr[3:0] == i_scan_row;
	endproperty
	a_tall_addr: assert property (p_tall_addr) else $error("5x10 address wrong"); // see RULE_12

	property p_tall_cursor;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req && code_is_user && glyph_fmt == FMT_5X10 && i_scan_row == 4'ha |=>
			(o_scan_dots & $past(i_cursor_dots)) == $past(i_cursor_dots);
	endproperty
	a_tall_cursor: assert property (p_tall_cursor) else $error("5x10 cursor row"); // see RULE_13

	property p_outside_dark;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req && !row_in_cell |=> o_scan_dots == DOTS_RESET;
	endproperty
	a_outside_dark: assert property (p_outside_dark) else $error("row past cell lit"); // see RULE_01

	property p_counter_step;
		@(posedge i_ref_clk) disable iff (i_reset)
		(host_op == HOST_WRITE || host_op == HOST_READ) |=>
			o_address_counter == ($past(i_entry_incr)
				? $past(address_counter_ff) + ADDR_STEP
				: $past(address_counter_ff) - ADDR_STEP);
	endproperty
	a_counter_step: assert property (p_counter_step) else $error("counter did not step"); // see RULE_14

	property p_host_read;
		@(posedge i_ref_clk) disable iff (i_reset)
		host_op == HOST_READ |=>
			o_host_rdata_valid && o_host_rdata == $past(ram_host_data) ##1
			(o_host_rdata_valid == $past(host_op == HOST_READ));
	endproperty
	a_host_read: assert property (p_host_read) else $error("host read answer wrong"); // see RULE_16

	property p_write_visible;
		@(posedge i_ref_clk) disable iff (i_reset)
		s_write_then_scan |-> ram_scan_data == $past(i_host_wdata);
	endproperty
	a_write_visible: assert property (p_write_visible) else $error("write not seen"); // see RULE_02

	// Host port holds its state between accesses
	property p_host_idle;
		@(posedge i_ref_clk) disable iff (i_reset)
		host_op == HOST_IDLE |=>
			!o_host_rdata_valid && o_address_counter == $past(address_counter_ff);
	endproperty
	a_host_idle: assert property (p_host_idle) else $error("counter moved"); // see RULE_14

	property p_addr_load;
		@(posedge i_ref_clk) disable iff (i_reset)
		host_op == HOST_LOAD |=> o_address_counter == $past(i_host_addr) && !o_host_rdata_valid;
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("load missed"); // see RULE_14

	property p_rdata_hold;
		@(posedge i_ref_clk) disable iff (i_reset)
		host_op != HOST_READ |=> $stable(o_host_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // see RULE_16

	// Scan port answers every request and holds otherwise
	property p_scan_answer;
		@(posedge i_ref_clk) disable iff (i_reset)
		i_scan_req |=>
			o_scan_valid && o_scan_fixed == $past(i_scan_code[CODE_W-1:CODE_FONT_LSB] != '0);
	endproperty
	a_scan_answer: assert property (p_scan_answer) else $error("no answer"); // see RULE_10

	property p_scan_idle;
		@(posedge i_ref_clk) disable iff (i_reset)
		!i_scan_req |=>
			!o_scan_valid && $stable(o_scan_dots) && $stable(o_scan_fixed);
	endproperty
	a_scan_idle: assert property (p_scan_idle) else $error("scan output moved"); // see RULE_16

endmodule

`default_nettype wire
